// ===== rtl/ccr_config_control.sv
// Purpose: Configuration control register with lock bits, JTAG enable and 2-wire TDO select.
// Assumes: AHB-Lite slave, single word transfers, one clock, synchronous active-low reset.
// Notes:   Pin-select and module-disable registers live outside; this block gates their write strobes.
`timescale 1ns/1ps
module ccr_config_control (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        unlockDone,
    input  wire logic        jtagEnableStrap,
    output logic             pin_select_lock,
    output logic             module_disable_lock,
    output logic             jtag_port_enable,
    output logic             two_wire_tdo_use,
    output logic             pinSelectWrite,
    output logic             moduleDisableWrite,
    output logic      [31:0] peripheralWriteData
);
    import ccr_pkg::*;

    logic        unlockMeta;
    logic        unlockSync;
    logic        strapMeta;
    logic        strapSync;
    logic        strapLoad;
    logic        phaseWrite;
    logic [31:0] phaseAddr;
    logic        busWrite;
    logic        ctrlWrite;
    logic        pinLockValue;
    logic        modLockValue;
    logic        tdoValue;
    logic        jtagValue;
    logic        next_jtag;

    // The unlock and strap levels come from other logic that may not share our clock.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            unlockMeta <= 1'b0;
            unlockSync <= 1'b0;
            strapMeta  <= 1'b0;
            strapSync  <= 1'b0;
        end else begin
            unlockMeta <= unlockDone;
            unlockSync <= unlockMeta;
            strapMeta  <= jtagEnableStrap;
            strapSync  <= strapMeta;
        end
    end

    // The strap is taken on the fourth clock edge after reset release, once it has crossed the synchroniser.
    logic [1:0] strapCount;
    always_ff @(posedge clk) begin
        if (!resetn) begin
            strapCount <= 2'h0;
            strapLoad  <= 1'b0;
        end else begin
            strapLoad <= 1'b0;
            if (strapCount != CCR_STRAP_DONE_COUNT) begin
                strapCount <= strapCount + 2'h1;
                strapLoad  <= (strapCount == CCR_STRAP_LOAD_COUNT);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            phaseWrite <= 1'b0;
            phaseAddr  <= 32'h0000_0000;
        end else if (hready) begin
            phaseWrite <= hsel && htrans == CCR_HTRANS_NONSEQ && hwrite && hsize == CCR_HSIZE_WORD;
            phaseAddr  <= {haddr[31:2], 2'h0};
        end
    end

    assign busWrite  = phaseWrite;
    assign ctrlWrite = busWrite && phaseAddr == CCR_CFG_CTRL_OFFSET;

    ccr_field_reg #(
        .RESET_VALUE (CCR_PIN_LOCK_RESET)
    ) pinLockReg (
        .clk         (clk),
        .resetn      (resetn),
        .writeEnable (ctrlWrite && unlockSync),
        .writeData   (hwdata[CCR_PIN_LOCK_BIT]),
        .value       (pinLockValue)
    );

    ccr_field_reg #(
        .RESET_VALUE (CCR_MOD_LOCK_RESET)
    ) modLockReg (
        .clk         (clk),
        .resetn      (resetn),
        .writeEnable (ctrlWrite && unlockSync),
        .writeData   (hwdata[CCR_MOD_LOCK_BIT]),
        .value       (modLockValue)
    );

    ccr_field_reg #(
        .RESET_VALUE (CCR_TDO_USE_RESET)
    ) tdoReg (
        .clk         (clk),
        .resetn      (resetn),
        .writeEnable (ctrlWrite),
        .writeData   (hwdata[CCR_TDO_USE_BIT]),
        .value       (tdoValue)
    );

    // Software writes take priority over a strap load in the same cycle.
    always_comb begin
        next_jtag = jtagValue;
        if (strapLoad) begin
            next_jtag = strapSync;
        end
        if (ctrlWrite) begin
            next_jtag = hwdata[CCR_JTAG_EN_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            jtagValue <= CCR_JTAG_EN_RESET;
        end else begin
            jtagValue <= next_jtag;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            pin_select_lock     <= CCR_PIN_LOCK_RESET;
            module_disable_lock <= CCR_MOD_LOCK_RESET;
            jtag_port_enable    <= CCR_JTAG_EN_RESET;
            two_wire_tdo_use    <= CCR_TDO_USE_RESET;
        end else begin
            pin_select_lock     <= pinLockValue;
            module_disable_lock <= modLockValue;
            jtag_port_enable    <= jtagValue;
            two_wire_tdo_use    <= tdoValue;
        end
    end

    // Forwarded peripheral writes are one cycle late and carry data registered alongside.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            pinSelectWrite      <= 1'b0;
            moduleDisableWrite  <= 1'b0;
            peripheralWriteData <= 32'h0000_0000;
        end else begin
            pinSelectWrite      <= busWrite && phaseAddr == CCR_PIN_SEL_OFFSET && !pinLockValue;
            moduleDisableWrite  <= busWrite && phaseAddr == CCR_MOD_DIS_OFFSET && !modLockValue;
            peripheralWriteData <= busWrite ? hwdata : peripheralWriteData;
        end
    end

    // A read whose address phase overlaps the data phase of a register write must see the new value,
    // so the pending write is forwarded into the read word with the same gating the fields use.
    logic [31:0] readWord;
    always_comb begin
        readWord                   = CCR_ONES_MASK;
        readWord[CCR_PIN_LOCK_BIT] = (ctrlWrite && unlockSync) ? hwdata[CCR_PIN_LOCK_BIT] : pinLockValue;
        readWord[CCR_MOD_LOCK_BIT] = (ctrlWrite && unlockSync) ? hwdata[CCR_MOD_LOCK_BIT] : modLockValue;
        readWord[CCR_JTAG_EN_BIT]  = next_jtag;
        readWord[CCR_TDO_USE_BIT]  = ctrlWrite ? hwdata[CCR_TDO_USE_BIT] : tdoValue;
    end

    // Read data is registered at the address phase so it stands during the data phase.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && htrans == CCR_HTRANS_NONSEQ && !hwrite) begin
            hrdata <= ({haddr[31:2], 2'h0} == CCR_CFG_CTRL_OFFSET) ? readWord : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end
endmodule

// ===== rtl/ccr_field_reg.sv
// Purpose: One writable control bit with a gated write enable.
// Assumes: Synchronous active-low reset.
// Notes:   The reset value is a constant; loading a strap is done by the caller.
`timescale 1ns/1ps
module ccr_field_reg #(
    parameter logic RESET_VALUE = 1'b0
) (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic writeEnable,
    input  wire logic writeData,
    output logic      value
);
    always_ff @(posedge clk) begin
        if (!resetn) begin
            value <= RESET_VALUE;
        end else if (writeEnable) begin
            value <= writeData;
        end
    end
endmodule

// ===== rtl/ccr_pkg.sv
// Purpose: Constants for the configuration control register block.
// Assumes: 32-bit AHB-Lite register bus, 100 MHz clock.
// Notes:   How it works is summarised below.
// How it works
// - Pin-select lock set blocks every write to the pin-select registers.
// - Module-disable lock set blocks every write to the module-disable registers.
// - Lock bits change only after the system unlock sequence.
// - JTAG port enable is read/write, resets to one, enables the port.
// - Two-wire TDO bit is read/write; one means the 2-wire protocol uses TDO.
// - Bits 2 and 1 read as one; writes to them are ignored.
// - Bits 31-14 and 11-4 read as zero; writes to them are ignored.
// - JTAG enable reset value comes from the nonvolatile configuration word.
package ccr_pkg;
    localparam logic [31:0] CCR_CFG_CTRL_OFFSET   = 32'h0000_0000;
    localparam logic [31:0] CCR_PIN_SEL_OFFSET    = 32'h0000_0010;
    localparam logic [31:0] CCR_MOD_DIS_OFFSET    = 32'h0000_0020;
    localparam int          CCR_PIN_LOCK_BIT      = 13;
    localparam int          CCR_MOD_LOCK_BIT      = 12;
    localparam int          CCR_JTAG_EN_BIT       = 3;
    localparam int          CCR_TDO_USE_BIT       = 0;
    localparam logic [31:0] CCR_ONES_MASK         = 32'h0000_0006;
    localparam logic        CCR_PIN_LOCK_RESET    = 1'b0;
    localparam logic        CCR_MOD_LOCK_RESET    = 1'b0;
    localparam logic        CCR_TDO_USE_RESET     = 1'b1;
    localparam logic        CCR_JTAG_EN_RESET     = 1'b1;
    localparam logic [1:0]  CCR_HTRANS_NONSEQ     = 2'h2;
    localparam logic [2:0]  CCR_HSIZE_WORD        = 3'h2;
    localparam logic [1:0]  CCR_STRAP_LOAD_COUNT  = 2'h2;
    localparam logic [1:0]  CCR_STRAP_DONE_COUNT  = 2'h3;
endpackage

// ===== verification/ccr_config_control_assertions.sv
// Purpose: Port checks for the configuration control register.
// Assumes: Zero wait states; register at 0x00, forwards at 0x10 and 0x20.
// Notes:   Field outputs trail the register by one cycle.
`timescale 1ns/1ps
module ccr_config_control_assertions (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hresp,
    input wire logic        unlockDone,
    input wire logic        pin_select_lock,
    input wire logic        module_disable_lock,
    input wire logic        jtag_port_enable,
    input wire logic        two_wire_tdo_use,
    input wire logic        pinSelectWrite,
    input wire logic        moduleDisableWrite
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence acc(logic w, logic [31:0] a);
        hready && htrans == 2'h2 && hwrite == w && haddr == a;
    endsequence
    pin_gate_a: assert property (
        acc(1, 32'h10) ##1 1 |=> pinSelectWrite != pin_select_lock) else $error("pin forward wrong");
    mod_gate_a: assert property (
        acc(1, 32'h20) ##1 1 |=> moduleDisableWrite != module_disable_lock) else $error("module forward wrong");
    lock_hold_a: assert property (
        !unlockDone [*5] |=> $stable(pin_select_lock) && $stable(module_disable_lock)) else $error("lock moved");
    field_write_a: assert property (
        acc(1, 32'h0) ##3 1 |-> jtag_port_enable == $past(hwdata[3], 2) && two_wire_tdo_use == $past(hwdata[0], 2))
        else $error("field not written");
    lock_write_a: assert property (
        unlockDone [*3] ##0 acc(1, 32'h0) ##3 1 |-> pin_select_lock == $past(hwdata[13], 2)
        && module_disable_lock == $past(hwdata[12], 2)) else $error("lock not written");
    cfg_read_a: assert property (
        acc(0, 32'h0) ##1 1 |=> $past(hrdata) == {18'h0, pin_select_lock, module_disable_lock, 8'h0, jtag_port_enable, 2'b11,
        two_wire_tdo_use}) else $error("read layout wrong");
    unmapped_read_a: assert property (acc(0, 32'h40) |=> hrdata == 32'h0) else $error("unmapped read not zero");
    okay_resp_a: assert property (hresp == 1'b0) else $error("response not okay");
endmodule
bind ccr_config_control ccr_config_control_assertions u_ccr_config_control_assertions (.clk, .resetn, .haddr,
    .htrans, .hwrite, .hwdata, .hready, .hrdata, .hresp, .unlockDone, .pin_select_lock, .module_disable_lock,
    .jtag_port_enable, .two_wire_tdo_use, .pinSelectWrite, .moduleDisableWrite);

// ===== verification/config_control_register_tb_top.sv
// Purpose: Self-checking bench for the configuration control register.
// Assumes: Strap low for the first run, so the JTAG enable reloads to zero; high after the second reset.
// Notes:   Transfers are serialised and wait on hreadyout.
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
    $display("mismatch %s expected %h seen %h", n, e, g); end end
module config_control_register_tb_top;
    import ccr_pkg::*;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        unlockDone = 1'b0;
    logic        jtagStrap = 1'b0;
    logic [31:0] hrdata, peripheralWriteData, q;
    logic        hreadyout, hresp, pin_select_lock, module_disable_lock, jtag_port_enable;
    logic        two_wire_tdo_use, pinSelectWrite, moduleDisableWrite;
    int          fail_count = 0, cmp_count = 0, pinCnt = 0, modCnt = 0;
    ccr_config_control u_ccr_config_control (.clk, .resetn, .hsel(1'b1), .haddr, .htrans, .hwrite,
        .hsize(CCR_HSIZE_WORD), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .unlockDone,
        .jtagEnableStrap(jtagStrap), .pin_select_lock, .module_disable_lock, .jtag_port_enable, .two_wire_tdo_use,
        .pinSelectWrite, .moduleDisableWrite, .peripheralWriteData);
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (pinSelectWrite === 1'b1) pinCnt++;
        if (moduleDisableWrite === 1'b1) modCnt++;
    end
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        htrans <= CCR_HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= a;
        @(posedge clk iff hreadyout === 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk iff hreadyout === 1'b1);
        q = hrdata;
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        `CHK("read data", e, q)
    endtask
    task automatic unlock(input logic u);
        unlockDone <= u;
        repeat (3) @(posedge clk);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge clk);
        fail_count++;
        give_verdict();
    end
    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        repeat (5) @(posedge clk);
        rd(32'h0, 32'h7);
        xfer(1'b1, 32'h0, 32'hffff_ffff);
        rd(32'h0, 32'hf);
        xfer(1'b1, 32'h0, 32'h0);
        rd(32'h0, 32'h6);
        unlock(1'b1);
        xfer(1'b1, 32'h0, 32'h3009);
        rd(32'h0, 32'h300f);
        xfer(1'b1, 32'h10, 32'h5);
        xfer(1'b1, 32'h20, 32'h5);
        unlock(1'b0);
        xfer(1'b1, 32'h0, 32'h0);
        rd(32'h0, 32'h3006);
        unlock(1'b1);
        xfer(1'b1, 32'h0, 32'h1000);
        xfer(1'b1, 32'h10, 32'ha5);
        repeat (2) @(posedge clk);
        `CHK("forwarded data", 32'ha5, peripheralWriteData)
        xfer(1'b1, 32'h20, 32'h5a);
        rd(32'h40, 32'h0);
        repeat (2) @(posedge clk);
        `CHK("pin-select pulses", 1, pinCnt)
        `CHK("module-disable pulses", 0, modCnt)
        jtagStrap <= 1'b1;
        resetn    <= 1'b0;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        repeat (5) @(posedge clk);
        rd(32'h0, 32'hf);
        give_verdict();
    end
endmodule
